// File: core/sdram_write_precharge_power.sv
// Purpose: write bursts, precharge, power-down and clock suspend of one sdram
// Assumes: command pins come from logic on the same clock
// Notes: read data path is outside this block, dq stays undriven
`timescale 1ns/100ps
`include "sdram_defs.svh"
module sdram_write_precharge_power #(
	parameter int ROW_W = 11,
	parameter int COL_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [10:0] addr,
	input wire sdram_pkg::bank_t bank_select_inputs,
	// data pins
	input wire sdram_pkg::lane_t dqm,
	input wire sdram_pkg::word_t dq_in,
	output logic dq_oe_q,
	// mode settings
	input wire logic [2:0] burst_len_code,
	input wire logic write_burst_mode_bit,
	// state
	output logic [3:0] bank_open_q,
	output logic [3:0] ap_pending_q,
	output logic burst_active_q,
	output logic suspend_q,
	output logic power_down_q,
	output logic active_pd_q,
	// peek port
	input wire sdram_pkg::bank_t peek_bank,
	input wire logic [ROW_W-1:0] peek_row,
	input wire logic [COL_W-1:0] peek_col,
	output sdram_pkg::word_t peek_data_q
);
	import sdram_pkg::*;

	localparam int AW = 2 + ROW_W + COL_W;
	localparam ap_cnt_t AP_LOAD = ap_cnt_t'(`AP_CYC);
	localparam ap_cnt_t TWR_LOAD = ap_cnt_t'(`TWR_CYC);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	power_state_t pwr_q, pwr_d;
	logic susp_d, pd_d, act_pd_d;
	logic b_act_d, wap_q, wap_d, wfull_q, wfull_d;
	bank_t ba, wbank_q, wbank_d, mem_bank;
	logic [COL_W-1:0] wcol_q, wcol_d, wmask_q, wmask_d, mem_col, cmask;
	logic [COL_W:0] wleft_q, wleft_d, blen;
	logic full_page, mem_we;
	logic [3:0] ap_full, ap_twr;
	logic [ROW_W-1:0] open_row [4];
	logic [2:0] cmd_code;
	logic cmd_ok, nop_cmd, cmd_sel, is_act, is_read, is_write, is_bterm, is_pre, pre_hit;

	function automatic logic [COL_W-1:0] col_step(input logic [COL_W-1:0] c,
		input logic [COL_W-1:0] m);
		col_step = (c & ~m) | ((c + 1'b1) & m);
	endfunction : col_step

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	assign ba = bank_select_inputs;
	assign cmd_code = {ras_n, cas_n, we_n};
	// commands and write data count only while running and not suspended
	assign cmd_ok = (pwr_q == PWR_RUN) && !suspend_q;
	assign nop_cmd = cs_n || (cmd_code == `CMD_NOP);
	assign cmd_sel = cmd_ok && !cs_n;
	assign is_act = cmd_sel && (cmd_code == `CMD_ACTIVE) && !bank_open_q[ba];
	assign is_read = cmd_sel && (cmd_code == `CMD_READ) && bank_open_q[ba];
	assign is_write = cmd_sel && (cmd_code == `CMD_WRITE) && bank_open_q[ba];
	assign is_bterm = cmd_sel && (cmd_code == `CMD_BTERM);
	assign is_pre = cmd_sel && (cmd_code == `CMD_PRE);
	assign pre_hit = is_pre && (addr[`ALL_BANK_BIT] || (ba == wbank_q));

	// ----------------------------------------
	// burst length
	// ----------------------------------------
	always_comb begin
		full_page = (burst_len_code == `BL_FULL);
		blen = {{COL_W{1'b0}}, 1'b1};
		if (!burst_len_code[2]) begin
			blen = blen << burst_len_code[1:0];
		end
		if (write_burst_mode_bit) begin
			full_page = 1'b0;
			blen = {{COL_W{1'b0}}, 1'b1};
		end
		cmask = full_page ? '1 : (blen[COL_W-1:0] - 1'b1);
	end

	// ----------------------------------------
	// write burst
	// ----------------------------------------
	always_comb begin
		b_act_d = burst_active_q;
		wbank_d = wbank_q;
		wcol_d = wcol_q;
		wleft_d = wleft_q;
		wfull_d = wfull_q;
		wap_d = wap_q;
		wmask_d = wmask_q;
		mem_we = 1'b0;
		mem_bank = wbank_q;
		mem_col = wcol_q;
		ap_full = 4'h0;
		ap_twr = 4'h0;
		if (is_write) begin
			if (burst_active_q && wap_q && (wbank_q != ba)) begin
				ap_twr[wbank_q] = 1'b1;
			end
			mem_we = 1'b1;
			mem_bank = ba;
			mem_col = addr[COL_W-1:0];
			wbank_d = ba;
			wmask_d = cmask;
			wfull_d = full_page;
			wap_d = addr[`AUTO_PRE_BIT];
			wcol_d = col_step(addr[COL_W-1:0], cmask);
			wleft_d = blen - 1'b1;
			b_act_d = full_page || (blen != {{COL_W{1'b0}}, 1'b1});
			if (!b_act_d && addr[`AUTO_PRE_BIT]) begin
				ap_full[ba] = 1'b1;
			end
		end else if (burst_active_q && cmd_ok) begin
			if (is_read || is_bterm || pre_hit) begin
				b_act_d = 1'b0;
				if (is_read && wap_q) begin
					ap_twr[wbank_q] = 1'b1;
				end
			end else begin
				mem_we = 1'b1;
				wcol_d = col_step(wcol_q, wmask_q);
				wleft_d = wleft_q - 1'b1;
				if (!wfull_q && (wleft_q == {{COL_W{1'b0}}, 1'b1})) begin
					b_act_d = 1'b0;
					if (wap_q) begin
						ap_full[wbank_q] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			burst_active_q <= 1'b0;
			wbank_q <= 2'h0;
			wcol_q <= '0;
			wleft_q <= '0;
			wfull_q <= 1'b0;
			wap_q <= 1'b0;
			wmask_q <= '0;
			dq_oe_q <= 1'b0;
		end else begin
			burst_active_q <= b_act_d;
			wbank_q <= wbank_d;
			wcol_q <= wcol_d;
			wleft_q <= wleft_d;
			wfull_q <= wfull_d;
			wap_q <= wap_d;
			wmask_q <= wmask_d;
			dq_oe_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// banks and auto precharge
	// ----------------------------------------
	for (genvar b = 0; b < 4; b++) begin : g_bank
		ap_cnt_t cnt_q, cnt_d;
		logic open_q, open_d, pend_q;
		logic [ROW_W-1:0] row_q, row_d;
		always_comb begin
			cnt_d = cnt_q;
			open_d = open_q;
			row_d = row_q;
			if (is_act && (ba == b)) begin
				open_d = 1'b1;
				row_d = addr[ROW_W-1:0];
			end
			if (is_pre && (addr[`ALL_BANK_BIT] || (ba == b))) begin
				open_d = 1'b0;
				cnt_d = '0;
			end else if (ap_full[b]) begin
				cnt_d = AP_LOAD;
			end else if (ap_twr[b]) begin
				cnt_d = TWR_LOAD;
			end else if ((cnt_q != '0) && !suspend_q) begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == ap_cnt_t'(1)) begin
					open_d = 1'b0;
				end
			end
		end
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				cnt_q <= '0;
				open_q <= 1'b0;
				pend_q <= 1'b0;
				row_q <= '0;
			end else begin
				cnt_q <= cnt_d;
				open_q <= open_d;
				pend_q <= (cnt_d != '0);
				row_q <= row_d;
			end
		end
		assign bank_open_q[b] = open_q;
		assign ap_pending_q[b] = pend_q;
		assign open_row[b] = row_q;
	end

	// ----------------------------------------
	// power-down and clock suspend
	// ----------------------------------------
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			PWR_RUN: begin
				if (!suspend_q && !cke && nop_cmd && !burst_active_q) begin
					pwr_d = (|bank_open_q) ? PWR_ACT_DOWN : PWR_PRE_DOWN;
				end
			end
			default: begin
				if (cke && nop_cmd) begin
					pwr_d = PWR_RUN;
				end
			end
		endcase
		// gate low freezes the following edge while a burst is live
		susp_d = (pwr_d == PWR_RUN) && !cke && b_act_d;
		pd_d = (pwr_d != PWR_RUN);
		act_pd_d = (pwr_d == PWR_ACT_DOWN);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_q <= PWR_RUN;
			suspend_q <= 1'b0;
			power_down_q <= 1'b0;
			active_pd_q <= 1'b0;
		end else begin
			pwr_q <= pwr_d;
			suspend_q <= susp_d;
			power_down_q <= pd_d;
			active_pd_q <= act_pd_d;
		end
	end

	// ----------------------------------------
	// cell array
	// ----------------------------------------
	sdram_store #(
		.AW(AW)
	) sdram_store_i (
		.clk(clk),
		.resetn(resetn),
		.wr_en(mem_we),
		.wr_addr({mem_bank, open_row[mem_bank], mem_col}),
		.wr_lane_en(~dqm),
		.wr_data(dq_in),
		.rd_addr({peek_bank, peek_row, peek_col}),
		.rd_data_q(peek_data_q)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence stop_seq;
		!mem_we ##1 !burst_active_q;
	endsequence

	capture_write_a: assert property (is_write |-> mem_we && (mem_col == addr[COL_W-1:0]))
		else $error("write data not taken on command edge");
	idle_ignore_a: assert property (!burst_active_q && !is_write |-> !mem_we)
		else $error("data written outside a burst");
	page_wrap_a: assert property (burst_active_q && mem_we && !is_write && wfull_q
		&& (&wcol_q) |=> (wcol_q == '0))
		else $error("full page column did not wrap");
	new_write_a: assert property (is_write |=> (wbank_q == $past(ba)))
		else $error("new write did not take over the burst");
	read_stop_a: assert property (is_read && !is_write |-> stop_seq)
		else $error("read did not stop the write burst");
	bterm_stop_a: assert property (is_bterm |-> stop_seq)
		else $error("burst terminate did not stop the burst");
	pre_all_a: assert property (is_pre && addr[`ALL_BANK_BIT] |=> (bank_open_q == 4'h0))
		else $error("precharge all left a bank open");
	ap_wait_a: assert property (ap_full[0] |=> bank_open_q[0] && ap_pending_q[0])
		else $error("auto precharge closed the row too early");
	ap_done_a: assert property ((g_bank[0].cnt_q == ap_cnt_t'(1)) && !suspend_q
		&& !ap_full[0] && !ap_twr[0] |=> !bank_open_q[0])
		else $error("auto precharge did not close the row");
	ap_interrupt_a: assert property (burst_active_q && wap_q && (is_read
		|| (is_write && (ba != wbank_q))) |-> ap_twr != 4'h0)
		else $error("interrupted auto precharge not scheduled");
	single_write_a: assert property (is_write && write_burst_mode_bit |=> !burst_active_q)
		else $error("single write mode burst continued");
	pd_entry_a: assert property ((pwr_q == PWR_RUN) && !suspend_q && !cke && nop_cmd
		&& !burst_active_q |=> power_down_q && (active_pd_q == $past(|bank_open_q)))
		else $error("power-down not entered");
	pd_quiet_a: assert property (power_down_q |-> !mem_we ##1 (power_down_q || $past(cke)))
		else $error("write accepted in power-down");
	pd_exit_a: assert property (power_down_q && cke && nop_cmd |=> !power_down_q)
		else $error("power-down not left");
	susp_hold_a: assert property (suspend_q |-> !mem_we ##1 ($stable(wcol_q)
		&& $stable(wleft_q)))
		else $error("suspended edge moved the burst");
	susp_enter_a: assert property (suspend_q && !cke |=> suspend_q)
		else $error("suspend released while gate low");
	susp_exit_a: assert property (suspend_q && cke |=> !suspend_q)
		else $error("suspend held after gate high");
endmodule : sdram_write_precharge_power

// File: shared/sdram_defs.svh
// Purpose: constants of the sdram write, precharge and power block
// Assumes: one 100 MHz clock, pins sampled on its rising edge
// Notes: times in ns, counts derived from them
`ifndef SDRAM_DEFS_SVH
`define SDRAM_DEFS_SVH

// ----------------------------------------
// command codes on ras_n, cas_n, we_n
// ----------------------------------------
`define CMD_NOP 3'h7
`define CMD_ACTIVE 3'h3
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4
`define CMD_BTERM 3'h6
`define CMD_PRE 3'h2

// ----------------------------------------
// address fields and burst codes
// ----------------------------------------
`define AUTO_PRE_BIT 10
`define ALL_BANK_BIT 10
`define BL_FULL 3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define TWR_NS 10
`define TWR_CYC ((`TWR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AP_CYC (1 + `TWR_CYC)

`endif

// File: shared/sdram_pkg.sv
// Purpose: types of the sdram write, precharge and power block
// Assumes: four banks, 32-bit data in four byte lanes
// Notes: constants live in sdram_defs.svh
package sdram_pkg;
	typedef enum logic [1:0] {PWR_RUN, PWR_PRE_DOWN, PWR_ACT_DOWN} power_state_t;
	typedef logic [31:0] word_t;
	typedef logic [3:0] lane_t;
	typedef logic [1:0] bank_t;
	typedef logic [3:0] ap_cnt_t;
endpackage : sdram_pkg

// File: core/sdram_store.sv
// Purpose: cell array with byte-lane writes and a registered peek read
// Assumes: write and read on the same clock
// Notes: no reset on the cells, only on the read register
`timescale 1ns/100ps
module sdram_store #(
	parameter int AW = 21
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire sdram_pkg::lane_t wr_lane_en,
	input wire sdram_pkg::word_t wr_data,
	// peek side
	input wire logic [AW-1:0] rd_addr,
	output sdram_pkg::word_t rd_data_q
);
	import sdram_pkg::*;

	// ----------------------------------------
	// byte lanes and peek read
	// ----------------------------------------
	// one array per lane, so no two processes write the same variable
	for (genvar l = 0; l < 4; l++) begin : g_lane
		logic [7:0] cells [2**AW];
		always_ff @(posedge clk) begin
			if (wr_en && wr_lane_en[l]) begin
				cells[wr_addr] <= wr_data[l*8 +: 8];
			end
		end
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				rd_data_q[l*8 +: 8] <= 8'h00;
			end else begin
				rd_data_q[l*8 +: 8] <= cells[rd_addr];
			end
		end
	end
endmodule : sdram_store

// File: tb/sdram_ctrl_model.sv
// Purpose: memory controller model driving the sdram command and data pins
// Assumes: pins change 1 ns after the rising edge, one call per edge
// Notes: callers pass fresh data every edge so stale values never look valid
`timescale 1ns/100ps
`include "sdram_defs.svh"
module sdram_ctrl_model #(
	parameter int TRP_CYC = 2
) (
	// clock
	input wire logic clk,
	// pins
	output logic cke,
	output logic cs_n,
	output logic [2:0] cmd,
	output logic [10:0] addr,
	output sdram_pkg::bank_t bank,
	output sdram_pkg::lane_t dqm,
	output sdram_pkg::word_t dq
);
	import sdram_pkg::*;
	logic quiet = 1'b0;
	initial begin
		cke = 1'b1;
		cs_n = 1'b0;
		cmd = `CMD_NOP;
		addr = 11'h000;
		bank = 2'h0;
		dqm = 4'h0;
		dq = 32'h0;
	end
	task drive(input logic c, input logic [2:0] op, input bank_t b, input logic [10:0] a,
		input word_t d, input lane_t m);
		@(posedge clk);
		#1;
		cke = c;
		cs_n = quiet && op == `CMD_NOP;
		cmd = op;
		bank = b;
		addr = a;
		dqm = m;
		dq = d;
	endtask : drive
	// only used after bursts without auto precharge
	task precharge(input bank_t b, input logic all);
		repeat (`TWR_CYC) drive(1'b1, `CMD_NOP, b, 11'h000, ~dq, 4'hf);
		drive(1'b1, `CMD_PRE, b, {all, 10'h000}, ~dq, 4'hf);
		repeat (TRP_CYC) drive(1'b1, `CMD_NOP, b, 11'h000, ~dq, 4'h0);
	endtask : precharge
	// leave power-down with an inhibit, well before refresh is due
	task wake();
		quiet = 1'b1;
		drive(1'b1, `CMD_NOP, bank, addr, ~dq, 4'h0);
		quiet = 1'b0;
	endtask : wake
endmodule : sdram_ctrl_model

// File: tb/sdram_write_precharge_power_test.sv
// Purpose: self-checking bench of the sdram write, precharge and power block
// Assumes: pins driven 1 ns after each edge, results sampled 0.5 ns after
// Notes: a note is compared at the edge that takes the pins driven with it
`timescale 1ns/100ps
`include "sdram_defs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module sdram_write_precharge_power_test;
	import sdram_pkg::*;
	typedef struct {int sel; word_t exp;} note_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cke, cs_n;
	logic [2:0] cmd;
	logic [10:0] addr;
	bank_t bank;
	lane_t dqm;
	word_t dq, peek_data_q, d;
	logic [2:0] burst_len_code = 3'h3;
	logic write_burst_mode_bit = 1'b1;
	bank_t peek_bank = 2'h0;
	logic [7:0] peek_col = 8'h00;
	logic dq_oe_q, burst_active_q, suspend_q, power_down_q, active_pd_q;
	logic [3:0] bank_open_q, ap_pending_q;
	logic [4:0] flags;
	logic [31:0] seed = 32'h1a;
	word_t exp_mem [4][16];
	note_t notes [$];
	note_t n;
	int cycles = 0;
	int error_cnt = 0;
	int checks_done = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	assign flags = {power_down_q, active_pd_q, suspend_q, burst_active_q, dq_oe_q};
	sdram_ctrl_model sdram_ctrl_model_i (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd),
		.addr(addr), .bank(bank), .dqm(dqm), .dq(dq));
	sdram_write_precharge_power #(.ROW_W(4), .COL_W(8)) sdram_write_precharge_power_i (
		.clk(clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]), .cas_n(cmd[1]),
		.we_n(cmd[0]), .addr(addr), .bank_select_inputs(bank), .dqm(dqm), .dq_in(dq),
		.dq_oe_q(dq_oe_q), .burst_len_code(burst_len_code),
		.write_burst_mode_bit(write_burst_mode_bit), .bank_open_q(bank_open_q),
		.ap_pending_q(ap_pending_q), .burst_active_q(burst_active_q), .suspend_q(suspend_q),
		.power_down_q(power_down_q), .active_pd_q(active_pd_q), .peek_bank(peek_bank),
		.peek_row(4'h1), .peek_col(peek_col), .peek_data_q(peek_data_q));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function word_t rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function word_t merge(input word_t o, input word_t nw, input lane_t m);
		for (int i = 0; i < 4; i++) if (!m[i]) o[8*i +: 8] = nw[8*i +: 8];
		return o;
	endfunction : merge
	task note(input int s, input word_t e);
		notes.push_back('{s, e});
	endtask : note
	task step(input logic c, input logic [2:0] op, input bank_t b, input logic [10:0] a,
		input lane_t m);
		d = rnd();
		sdram_ctrl_model_i.drive(c, op, b, a, d, m);
	endtask : step
	task verify(input bank_t b);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#1;
			peek_bank = b;
			peek_col = 8'(i);
			note(0, exp_mem[b][i]);
		end
	endtask : verify
	task summarize();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	// sampled before the next drive lands, so no race with the stimulus
	always @(posedge clk) begin
		#0.5;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.sel)
				0: `CHK("peek_data_q", n.exp, peek_data_q)
				1: `CHK("bank_open_q", n.exp[3:0], bank_open_q)
				2: `CHK("flags", n.exp[4:0], flags)
				4: `CHK("ap_pending_q", n.exp[3:0], ap_pending_q)
				default: `CHK("suspend_q", n.exp[0], suspend_q)
			endcase
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			summarize();
		end
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		#1;
		resetn = 1'b1;
		note(2, 32'h0);
		note(1, 32'h0);
		for (int b = 0; b < 2; b++) step(1'b1, `CMD_ACTIVE, bank_t'(b), 11'h001, 4'h0);
		note(1, 32'h3);
		for (int b = 0; b < 2; b++) for (int c = 15; c >= 0; c--) begin
			step(1'b1, `CMD_WRITE, bank_t'(b), 11'(c), 4'h0);
			exp_mem[b][c] = d;
		end
		repeat (3) step(1'b1, `CMD_NOP, 2'h0, 11'h000, 4'h0);
		verify(2'h0);
		verify(2'h1);
		write_burst_mode_bit = 1'b0;
		burst_len_code = 3'h2;
		for (int i = 0; i < 6; i++) begin
			step(1'b1, i ? `CMD_NOP : `CMD_WRITE, 2'h0, 11'h006, i == 2 ? 4'h2 : 4'h0);
			if (i < 4) exp_mem[0][4 + (i + 2) % 4] = merge(exp_mem[0][4 + (i + 2) % 4], d,
				i == 2 ? 4'h2 : 4'h0);
			if (i % 2) note(2, i == 1 ? 32'h2 : 32'h0);
		end
		burst_len_code = `BL_FULL;
		for (int i = 0; i < 6; i++) begin
			step(1'b1, i == 0 ? `CMD_WRITE : i == 4 ? `CMD_BTERM : `CMD_NOP, 2'h1, 11'h0fe, 4'h0);
			if (i == 2 || i == 3) exp_mem[1][i - 2] = d;
		end
		burst_len_code = 3'h3;
		for (int i = 0; i < 5; i++) begin
			step(1'b1, i == 0 ? `CMD_WRITE : i == 2 ? `CMD_READ : `CMD_NOP, 2'h0, 11'h008, 4'h0);
			if (i < 2) exp_mem[0][8 + i] = d;
		end
		burst_len_code = 3'h2;
		for (int i = 0; i < 7; i++) begin
			step(i == 1 || i == 2 ? 1'b0 : 1'b1, i ? `CMD_NOP : `CMD_WRITE, 2'h0, 11'h00c, 4'h0);
			if (i < 2 || i == 4 || i == 5) exp_mem[0][12 + i - (i > 3 ? 2 : 0)] = d;
			if (i == 2) note(3, 32'h1);
			if (i == 4) note(3, 32'h0);
		end
		burst_len_code = 3'h1;
		for (int i = 0; i < 5; i++) begin
			step(1'b1, i == 0 || i == 2 ? `CMD_WRITE : `CMD_NOP, i < 2 ? 2'h1 : 2'h0,
				i < 2 ? 11'h408 : 11'h000, 4'h0);
			if (i < 4) exp_mem[i < 2][i < 2 ? 8 + i : i - 2] = d;
			if (i == 2 || i == 3) note(1, i == 2 ? 32'h3 : 32'h1);
			if (i == 2 || i == 3) note(4, i == 2 ? 32'h2 : 32'h0);
		end
		// auto precharge write on bank 1 cut short by a write to bank 0
		step(1'b1, `CMD_ACTIVE, 2'h1, 11'h001, 4'h0);
		for (int i = 0; i < 4; i++) begin
			step(1'b1, i < 2 ? `CMD_WRITE : `CMD_NOP, i ? 2'h0 : 2'h1, i ? 11'h002 : 11'h40a, 4'h0);
			if (i == 0) exp_mem[1][10] = d;
			if (i == 1 || i == 2) exp_mem[0][i + 1] = d;
			if (i == 1 || i == 2) note(1, i == 1 ? 32'h3 : 32'h1);
			if (i == 1 || i == 2) note(4, i == 1 ? 32'h2 : 32'h0);
		end
		for (int b = 2; b < 4; b++) step(1'b1, `CMD_ACTIVE, bank_t'(b), 11'h001, 4'h0);
		note(1, 32'hd);
		step(1'b1, `CMD_WRITE, 2'h1, 11'h000, 4'h0);
		step(1'b1, `CMD_NOP, 2'h0, 11'h000, 4'h0);
		sdram_ctrl_model_i.precharge(2'h2, 1'b0);
		note(1, 32'h9);
		step(1'b0, `CMD_NOP, 2'h0, 11'h000, 4'h0);
		note(2, 32'h18);
		step(1'b0, `CMD_WRITE, 2'h0, 11'h003, 4'h0);
		sdram_ctrl_model_i.wake();
		note(2, 32'h0);
		sdram_ctrl_model_i.precharge(2'h2, 1'b1);
		note(1, 32'h0);
		step(1'b0, `CMD_NOP, 2'h0, 11'h000, 4'h0);
		note(2, 32'h10);
		sdram_ctrl_model_i.wake();
		note(2, 32'h0);
		verify(2'h0);
		verify(2'h1);
		repeat (2) @(posedge clk);
		summarize();
	end
endmodule : sdram_write_precharge_power_test
